// File: verilog/down_timer_pkg.sv
/*
  Package for the down-counting timer with pulse and tone outputs.
  Holds register offsets, reset values, field layouts and bus state codes.
  Assumes a 32-bit AHB-Lite slave in which every register takes one aligned word.
*/
package down_timer_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_COUNT_VALUE    = 8'h00;
  localparam logic [7:0] OFF_TIMER_CTRL_A   = 8'h04;
  localparam logic [7:0] OFF_TIMER_CTRL_B   = 8'h08;
  localparam logic [7:0] OFF_DIV_COUNT      = 8'h0C;
  localparam logic [7:0] OFF_PULSE_DUTY     = 8'h10;
  localparam logic [7:0] OFF_TONE_CTRL      = 8'h14;
  localparam logic [7:0] OFF_IRQ_FLAG_REG   = 8'h18;
  localparam logic [7:0] OFF_IRQ_ENABLE_REG = 8'h1C;
  localparam logic [7:0] OFF_PIN_GLOBAL     = 8'h20;

  // Bit positions of loose bits
  localparam int UNDERFLOW_BIT  = 3;
  localparam int GLOBAL_IRQ_BIT = 0;
  localparam int PIN_SEL_BIT    = 1;

  // Reset values
  localparam logic [7:0] RST_COUNT  = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_DUTY   = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h00;

  // Restart value when the reload holding register is not used
  localparam logic [7:0] FREE_RESTART = 8'hFF;
  localparam logic [7:0] COUNT_ZERO   = 8'h00;

  // Masks for divide ratios 1:2 .. 1:256
  localparam logic [7:0] DIV_MASK_FULL = 8'hFF;
  localparam logic [7:0] TONE_MASK_TOP = 8'h7F;
  localparam logic [2:0] RATE_TOP      = 3'h7;

  typedef struct packed {
    logic       pulse_out_en;
    logic       pulse_active_low;
    logic [2:0] rsv;
    logic       single_shot_sel;
    logic       reload_sel;
    logic       cnt_run_en;
  } timer_ctrl_a_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic       cnt_src_sel;
    logic       cnt_edge_sel;
    logic       div_enable_n;
    logic [2:0] div_rate_sel;
  } timer_ctrl_b_t;

  typedef struct packed {
    logic       tone_out_en;
    logic [2:0] rsv;
    logic [3:0] tone_freq_sel;
  } tone_ctrl_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR   = 3'b010,
    BUS_RD   = 3'b100
  } bus_state_t;

endpackage

// File: verilog/down_timer_pwm_buzzer.sv
/*
  Eight-bit down timer with prescaler, pulse-width output and tone divider
  sharing one output pin, reached over an AHB-Lite slave port.
  Assumes inputs synchronous to clk_sys_i and a single-master, word-only bus.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Count is eight bits and drops by one per prescaled tick while enabled.
// - Writing the count loads both the reload holding byte and the live count.
// - Reading the count returns the live count, not the reload byte.
// - Counting happens only while the run enable bit is set.
// - Source select picks the external count clock at 1, system clock at 0.
// - With external source, edge select 1 counts falling edges, 0 rising edges.
// - Active-low divider enable at 0 divides by 2 up to 256 per rate field.
// - The divider's current count is readable through a read-only register.
// - Single shot counts down once to zero and then stops.
// - Continuous mode restarts from reload byte or from 0xFF per reload select.
// - The wrap past zero marks the underflow event.
// - Underflow sets a sticky flag that only a written zero clears.
// - Interrupt asserts only with flag, its enable and global enable all set.
// - Pulse enable with pulse pin option drives pulse on the pin as output.
// - Polarity bit 1 makes the pulse active low, 0 active high.
// - Duty zero is never active; duty 0xFF is active for 255 ticks.
// - Tone enable with tone pin option drives the tone on the pin as output.
// - Tone select top bit picks divider or timer output; low bits pick ratio.
module down_timer_pwm_buzzer (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // External count clock
  input  wire logic        ext_count_clk_i,
  // Shared output pin
  output logic             shared_out_pin_o,
  output logic             shared_out_pin_oe_o,
  // Interrupt request
  output logic             irq_o
);
  import down_timer_pkg::*;

  bus_state_t    bus_state;
  logic [7:0]    wr_addr;
  timer_ctrl_a_t timer_ctrl_a;
  timer_ctrl_b_t timer_ctrl_b;
  tone_ctrl_t    tone_ctrl;
  logic [7:0]    count_value;
  logic [7:0]    reload_holding;
  logic [7:0]    div_count_value;
  logic [7:0]    pulse_duty_value;
  logic [7:0]    tone_cnt;
  logic          tone_signal;
  logic          underflow_flag;
  logic          underflow_irq_en;
  logic          global_irq_en;
  logic          pin_sel;
  logic          ext_prev;

  logic          addr_ok;
  logic          wr_now;
  logic          wr_count;
  logic          wr_ctrl_a;
  logic          src_tick;
  logic          div_tick;
  logic          t_tick;
  logic          run;
  logic          uflow;
  logic          tone_src;
  logic [7:0]    div_mask;
  logic [7:0]    tone_mask;
  logic          pulse_act;
  logic          next_flag;

  // Bus decode; hsize is ignored since only whole words are carried
  assign addr_ok   = hsel_i && hready_i && htrans_i[1];
  assign wr_now    = (bus_state == BUS_WR);
  assign wr_count  = wr_now && (wr_addr == OFF_COUNT_VALUE);
  assign wr_ctrl_a = wr_now && (wr_addr == OFF_TIMER_CTRL_A);

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    case (a)
      OFF_COUNT_VALUE:    read_byte = count_value;
      OFF_TIMER_CTRL_A:   read_byte = timer_ctrl_a;
      OFF_TIMER_CTRL_B:   read_byte = timer_ctrl_b;
      OFF_DIV_COUNT:      read_byte = div_count_value;
      OFF_PULSE_DUTY:     read_byte = pulse_duty_value;
      OFF_TONE_CTRL:      read_byte = tone_ctrl;
      OFF_IRQ_FLAG_REG:   read_byte = {4'h0, underflow_flag, 3'h0};
      OFF_IRQ_ENABLE_REG: read_byte = {4'h0, underflow_irq_en, 3'h0};
      OFF_PIN_GLOBAL:     read_byte = {6'h00, pin_sel, global_irq_en};
      default:            read_byte = 8'h00;
    endcase
  endfunction

  // Zero-wait slave: read data is captured in the address phase
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state   <= BUS_IDLE;
      wr_addr     <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      case (bus_state)
        BUS_IDLE, BUS_WR, BUS_RD: begin
          if (addr_ok && hwrite_i) begin
            bus_state <= BUS_WR;
            wr_addr   <= haddr_i[7:0];
          end else if (addr_ok) begin
            bus_state <= BUS_RD;
            hrdata_o  <= {24'h00_0000, read_byte(haddr_i[7:0])};
          end else begin
            bus_state <= BUS_IDLE;
          end
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_ctrl_b     <= RST_CTRL;
      tone_ctrl        <= RST_CTRL;
      pulse_duty_value <= RST_DUTY;
      underflow_irq_en <= 1'b0;
      global_irq_en    <= 1'b0;
      pin_sel          <= 1'b0;
    end else if (wr_now) begin
      case (wr_addr)
        OFF_TIMER_CTRL_B:   timer_ctrl_b     <= hwdata_i[7:0];
        OFF_TONE_CTRL:      tone_ctrl        <= hwdata_i[7:0];
        OFF_PULSE_DUTY:     pulse_duty_value <= hwdata_i[7:0];
        OFF_IRQ_ENABLE_REG: underflow_irq_en <= hwdata_i[UNDERFLOW_BIT];
        OFF_PIN_GLOBAL: begin
          global_irq_en <= hwdata_i[GLOBAL_IRQ_BIT];
          pin_sel       <= hwdata_i[PIN_SEL_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Count source and edge choice
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_count_clk_i;
    end
  end

  always_comb begin
    if (timer_ctrl_b.cnt_src_sel) begin
      src_tick = timer_ctrl_b.cnt_edge_sel ? (ext_prev && !ext_count_clk_i)
                                           : (!ext_prev && ext_count_clk_i);
    end else begin
      src_tick = 1'b1;
    end
  end

  // Divider ratio 2^(rate+1); a write to the count restarts it
  assign div_mask = DIV_MASK_FULL >> (RATE_TOP - timer_ctrl_b.div_rate_sel);
  assign div_tick = src_tick && ((div_count_value & div_mask) == div_mask);
  assign t_tick   = timer_ctrl_b.div_enable_n ? src_tick : div_tick;
  assign run      = timer_ctrl_a.cnt_run_en;
  assign uflow    = run && t_tick && (count_value == COUNT_ZERO);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_count_value <= 8'h00;
    end else if (wr_count) begin
      div_count_value <= 8'h00;
    end else if (run && src_tick && !timer_ctrl_b.div_enable_n) begin
      div_count_value <= div_count_value + 8'h01;
    end
  end

  // Live count and reload byte; a single shot clears the run bit itself
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_value    <= RST_COUNT;
      reload_holding <= RST_RELOAD;
    end else if (wr_count) begin
      count_value    <= hwdata_i[7:0];
      reload_holding <= hwdata_i[7:0];
    end else if (uflow && !timer_ctrl_a.single_shot_sel) begin
      count_value <= timer_ctrl_a.reload_sel ? reload_holding : FREE_RESTART;
    end else if (run && t_tick && !uflow) begin
      count_value <= count_value - 8'h01;
    end
  end

  // Software write wins over the stop of a single shot in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_ctrl_a <= RST_CTRL;
    end else if (wr_ctrl_a) begin
      timer_ctrl_a <= hwdata_i[7:0];
    end else if (uflow && timer_ctrl_a.single_shot_sel) begin
      timer_ctrl_a.cnt_run_en <= 1'b0;
    end
  end

  // Sticky flag: a new underflow beats a clearing write
  always_comb begin
    next_flag = underflow_flag;
    if (wr_now && (wr_addr == OFF_IRQ_FLAG_REG) && !hwdata_i[UNDERFLOW_BIT]) begin
      next_flag = 1'b0;
    end
    if (uflow) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      underflow_flag <= 1'b0;
      irq_o          <= 1'b0;
    end else begin
      underflow_flag <= next_flag;
      irq_o          <= underflow_flag && underflow_irq_en && global_irq_en;
    end
  end

  // Tone divider: toggles every 2^sel source ticks, giving 1:2 .. 1:256
  assign tone_src  = tone_ctrl.tone_freq_sel[3] ? uflow : div_tick;
  assign tone_mask = TONE_MASK_TOP >> (RATE_TOP - tone_ctrl.tone_freq_sel[2:0]);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tone_cnt    <= 8'h00;
      tone_signal <= 1'b0;
    end else if (!tone_ctrl.tone_out_en) begin
      tone_cnt    <= 8'h00;
      tone_signal <= 1'b0;
    end else if (tone_src) begin
      tone_cnt <= tone_cnt + 8'h01;
      if ((tone_cnt & tone_mask) == tone_mask) begin
        tone_signal <= !tone_signal;
      end
    end
  end

  // Duty above the reload value would never let the pulse go inactive
  assign pulse_act = run && (count_value < pulse_duty_value);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shared_out_pin_o    <= 1'b0;
      shared_out_pin_oe_o <= 1'b0;
    end else if (timer_ctrl_a.pulse_out_en && !pin_sel) begin
      shared_out_pin_o    <= pulse_act ^ timer_ctrl_a.pulse_active_low;
      shared_out_pin_oe_o <= 1'b1;
    end else if (tone_ctrl.tone_out_en && pin_sel) begin
      shared_out_pin_o    <= tone_signal;
      shared_out_pin_oe_o <= 1'b1;
    end else begin
      shared_out_pin_o    <= 1'b0;
      shared_out_pin_oe_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_load_both: assert property (wr_count |=>
    (count_value == $past(hwdata_i[7:0])) && (reload_holding == $past(hwdata_i[7:0])))
    else $error("count write did not load both count and reload");
  a_read_live: assert property ((addr_ok && !hwrite_i && haddr_i[7:0] == OFF_COUNT_VALUE)
    |=> hrdata_o == {24'h00_0000, $past(count_value)})
    else $error("count read did not return live count");
  a_hold_stopped: assert property ((!run && !wr_count) |=> $stable(count_value))
    else $error("count moved while stopped");
  a_dec_one: assert property ((run && t_tick && !uflow && !wr_count)
    |=> count_value == $past(count_value) - 8'h01)
    else $error("count did not drop by one");
  a_shot_stop: assert property ((uflow && timer_ctrl_a.single_shot_sel && !wr_count
    && !wr_ctrl_a) |=> (!run && count_value == COUNT_ZERO) ##1 $stable(count_value))
    else $error("single shot did not stop at zero");
  a_restart_val: assert property ((uflow && !timer_ctrl_a.single_shot_sel && !wr_count)
    |=> count_value == ($past(timer_ctrl_a.reload_sel) ? $past(reload_holding) : FREE_RESTART))
    else $error("wrong restart value");
  a_flag_sticky: assert property (uflow |=> underflow_flag)
    else $error("underflow did not set flag");
  a_irq_gate: assert property (irq_o |->
    $past(underflow_flag) && $past(underflow_irq_en) && $past(global_irq_en))
    else $error("interrupt without flag and enables");
  a_duty_zero: assert property ((timer_ctrl_a.pulse_out_en && !pin_sel
    && pulse_duty_value == 8'h00) |=> shared_out_pin_o == $past(timer_ctrl_a.pulse_active_low))
    else $error("pulse active with zero duty");
  // Pin select alone picks the route; the tone check still requires the pulse enable to be clear
  a_pin_drive: assert property ((tone_ctrl.tone_out_en && pin_sel
    && !timer_ctrl_a.pulse_out_en) |=> shared_out_pin_oe_o && shared_out_pin_o == $past(tone_signal))
    else $error("tone not driven on pin");

  // Flag and interrupt
  a_flag_clear: assert property ((wr_now && wr_addr == OFF_IRQ_FLAG_REG
    && !hwdata_i[UNDERFLOW_BIT] && !uflow) |=> !underflow_flag)
    else $error("written zero did not clear flag");

  a_flag_hold: assert property ((!uflow && !(wr_now && wr_addr == OFF_IRQ_FLAG_REG))
    |=> underflow_flag == $past(underflow_flag))
    else $error("flag changed without event or write");

  a_irq_raise: assert property ((underflow_flag && underflow_irq_en && global_irq_en)
    |=> irq_o)
    else $error("interrupt missing with flag and enables set");

  // Count source, edge and divider
  a_src_int: assert property (!timer_ctrl_b.cnt_src_sel |-> src_tick)
    else $error("system clock source did not tick");

  a_edge_rise: assert property ((timer_ctrl_b.cnt_src_sel && !timer_ctrl_b.cnt_edge_sel
    && src_tick) |-> (ext_count_clk_i && !ext_prev))
    else $error("tick without rising edge");

  a_edge_fall: assert property ((timer_ctrl_b.cnt_src_sel && timer_ctrl_b.cnt_edge_sel
    && src_tick) |-> (!ext_count_clk_i && ext_prev))
    else $error("tick without falling edge");

  a_div_bypass: assert property (timer_ctrl_b.div_enable_n |-> (t_tick == src_tick))
    else $error("bypassed divider changed the tick");

  a_div_hold: assert property ((!wr_count && !(run && src_tick
    && !timer_ctrl_b.div_enable_n)) |=> $stable(div_count_value))
    else $error("divider count moved while idle");

  a_read_div: assert property ((addr_ok && !hwrite_i && haddr_i[7:0] == OFF_DIV_COUNT)
    |=> hrdata_o == {24'h00_0000, $past(div_count_value)})
    else $error("divider read did not return its count");

  // Shared pin
  a_pulse_oe: assert property ((timer_ctrl_a.pulse_out_en && !pin_sel)
    |=> shared_out_pin_oe_o)
    else $error("pulse route did not drive the pin");

  a_pulse_level: assert property ((timer_ctrl_a.pulse_out_en && !pin_sel)
    |=> shared_out_pin_o == ($past(pulse_act) ^ $past(timer_ctrl_a.pulse_active_low)))
    else $error("pulse level or polarity wrong");

  a_pin_idle: assert property ((!(timer_ctrl_a.pulse_out_en && !pin_sel)
    && !(tone_ctrl.tone_out_en && pin_sel)) |=> !shared_out_pin_oe_o)
    else $error("pin driven with no route enabled");

  // Tone divider
  a_tone_off: assert property (!tone_ctrl.tone_out_en |=> !tone_signal)
    else $error("tone active while disabled");

  a_tone_toggle: assert property ((tone_ctrl.tone_out_en && tone_src
    && ((tone_cnt & tone_mask) == tone_mask)) |=> tone_signal != $past(tone_signal))
    else $error("tone did not toggle at divided rate");

endmodule

`default_nettype wire

// File: verif/ext_clk_src.sv
/*
  Far-side model: external count clock source and a pin load with pull-down.
  Assumes tasks are called from one bench process, synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_clk_src (
  // Clock
  input  wire logic clk_i,
  // Count clock out, idle low between bursts
  output var  logic ext_count_clk_o,
  // Pin load
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  output logic      pin_level_o
);
  initial ext_count_clk_o = 1'b0;
  // A released pin falls to the pull-down, never keeps the last value
  assign pin_level_o = pin_oe_i ? pin_i : 1'b0;
  // Each level held at least four cycles so the sampled edge detector cannot miss it
  task automatic level(input logic lv);
    @(posedge clk_i);
    ext_count_clk_o <= lv;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
/*
  Self-checking bench for the down timer with pulse and tone outputs.
  Assumes a zero-wait AHB-Lite slave and the far-side model ext_clk_src.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import down_timer_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h00000000;
  logic [1:0]  htrans    = 2'b00;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h00000000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        ext_clk;
  logic        pin;
  logic        pin_oe;
  logic        pin_lvl;
  logic        irq;
  logic [7:0]  q;
  int          errors = 0;
  int          total_checks = 0;
  int          act;
  int          tog;

  always #20 clk_sys_i = ~clk_sys_i;

  down_timer_pwm_buzzer DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(), .ext_count_clk_i(ext_clk), .shared_out_pin_o(pin),
    .shared_out_pin_oe_o(pin_oe), .irq_o(irq));
  ext_clk_src src (.clk_i(clk_sys_i), .ext_count_clk_o(ext_clk), .pin_i(pin),
    .pin_oe_i(pin_oe), .pin_level_o(pin_lvl));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  // Bounded wait: a stuck ready ends the run rather than hanging it
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("mismatch at %0t: bus hang", $time);
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    wait_rdy();
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  // Samples the resolved pin at falling edges, away from the update edge
  task automatic sample_pin(input int n);
    logic prev;
    act = 0;
    tog = 0;
    @(negedge clk_sys_i);
    prev = pin_lvl;
    repeat (n) begin
      @(negedge clk_sys_i);
      if (pin_lvl === 1'b1) act++;
      if (pin_lvl !== prev) tog++;
      prev = pin_lvl;
    end
  endtask

  task automatic t_oneshot();
    rd(8'h24);
    chk_byte(q, 8'h00);
    chk_bit(pin_oe, 1'b0);
    wr(OFF_COUNT_VALUE, 8'h05);
    repeat (20) @(posedge clk_sys_i);
    rd(OFF_COUNT_VALUE);
    chk_byte(q, 8'h05);
    wr(OFF_TIMER_CTRL_A, 8'h05);
    repeat (60) @(posedge clk_sys_i);
    rd(OFF_COUNT_VALUE);
    chk_byte(q, 8'h00);
    rd(OFF_TIMER_CTRL_A);
    chk_byte(q, 8'h04);
    rd(OFF_IRQ_FLAG_REG);
    chk_bit(q[UNDERFLOW_BIT], 1'b1);
    $display("test oneshot done");
  endtask
  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      wr(OFF_IRQ_ENABLE_REG, {4'h0, i[0], 3'h0});
      wr(OFF_PIN_GLOBAL, {7'h00, i[1]});
      repeat (2) @(posedge clk_sys_i);
      chk_bit(irq, i == 3);
    end
    wr(OFF_IRQ_FLAG_REG, 8'h08);
    repeat (2) @(posedge clk_sys_i);
    chk_bit(irq, 1'b1);
    wr(OFF_IRQ_FLAG_REG, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    chk_bit(irq, 1'b0);
    $display("test irq done");
  endtask
  task automatic t_reload();
    wr(OFF_COUNT_VALUE, 8'h03);
    wr(OFF_TIMER_CTRL_A, 8'h03);
    repeat (5) begin
      rd(OFF_COUNT_VALUE);
      chk_bit(q <= 8'h03, 1'b1);
    end
    wr(OFF_TIMER_CTRL_A, 8'h00);
    wr(OFF_COUNT_VALUE, 8'h03);
    wr(OFF_TIMER_CTRL_A, 8'h01);
    repeat (12) @(posedge clk_sys_i);
    rd(OFF_COUNT_VALUE);
    chk_bit(q > 8'h03, 1'b1);
    wr(OFF_TIMER_CTRL_A, 8'h00);
    $display("test reload done");
  endtask
  // Four rises, three falls: the edge choice shows in the final count
  task automatic t_ext();
    for (int e = 0; e < 2; e++) begin
      wr(OFF_TIMER_CTRL_B, {3'b001, e[0], 4'h8});
      wr(OFF_COUNT_VALUE, 8'h20);
      wr(OFF_TIMER_CTRL_A, 8'h01);
      src.pulses(3);
      src.level(1'b1);
      rd(OFF_COUNT_VALUE);
      chk_byte(q, e ? 8'h1D : 8'h1C);
      src.level(1'b0);
      wr(OFF_TIMER_CTRL_A, 8'h00);
    end
    for (int r = 0; r < 4; r++) begin
      wr(OFF_TIMER_CTRL_B, {5'b00100, r[2:0]});
      wr(OFF_COUNT_VALUE, 8'h40);
      wr(OFF_TIMER_CTRL_A, 8'h01);
      src.pulses(r == 3 ? 5 : 8);
      rd(r == 3 ? OFF_DIV_COUNT : OFF_COUNT_VALUE);
      chk_byte(q, r == 3 ? 8'h05 : 8'h40 - (8'h08 >> (r + 1)));
      wr(OFF_TIMER_CTRL_A, 8'h00);
    end
    $display("test external done");
  endtask
  task automatic t_pulse();
    logic [7:0] rl [4] = '{8'h04, 8'h04, 8'h04, 8'hFF};
    logic [7:0] dy [4] = '{8'h02, 8'h02, 8'h00, 8'hFF};
    int         n  [4] = '{50, 50, 50, 256};
    int         ex [4] = '{20, 20, 0, 255};
    wr(OFF_PIN_GLOBAL, 8'h00);
    wr(OFF_TIMER_CTRL_B, 8'h08);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_PULSE_DUTY, dy[i]);
      wr(OFF_COUNT_VALUE, rl[i]);
      wr(OFF_TIMER_CTRL_A, {1'b1, i == 1, 6'h03});
      repeat (4) @(posedge clk_sys_i);
      sample_pin(n[i]);
      chk_bit(pin_oe, 1'b1);
      chk_byte(8'(i == 1 ? n[i] - act : act), 8'(ex[i]));
      wr(OFF_TIMER_CTRL_A, 8'h00);
    end
    $display("test pulse done");
  endtask
  task automatic t_tone();
    logic [7:0] cb [3] = '{8'h00, 8'h00, 8'h08};
    logic [3:0] fs [3] = '{4'h0, 4'h1, 4'h8};
    int         ex [3] = '{20, 10, 10};
    wr(OFF_PIN_GLOBAL, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_TIMER_CTRL_B, cb[i]);
      wr(OFF_TONE_CTRL, {4'h8, fs[i]});
      wr(OFF_COUNT_VALUE, 8'h03);
      wr(OFF_TIMER_CTRL_A, 8'h03);
      repeat (8) @(posedge clk_sys_i);
      sample_pin(40);
      chk_bit(pin_oe, 1'b1);
      chk_byte(8'(tog), 8'(ex[i]));
    end
    wr(OFF_TONE_CTRL, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    chk_bit(pin_oe, 1'b0);
    $display("test tone done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_oneshot();
    t_irq();
    t_reload();
    t_ext();
    t_pulse();
    t_tone();
    wrap_up();
  end
endmodule
`default_nettype wire
